// ---- common/pll_cfg_pkg.sv ----
// constants for the pll dynamic configuration port
package pll_cfg_pkg;
	localparam int CFG_BITS = 81;
	localparam int EXT_CFG_BITS = 89;
	localparam int PHASE_LSB = 29;
	localparam int PHASE_W = 3;
	localparam int OUT_DIV_W = 5;
	localparam int OUT3_DIV_LSB = 24;
	localparam int OUT2_DIV_LSB = 19;
	localparam int OUT1_DIV_LSB = 14;
	localparam int FB_DIV_LSB = 7;
	localparam int LOOP_DIV_W = 7;
	localparam int IN_DIV_LSB = 0;
	localparam int SRC2_SEL_BIT = 32;
	localparam int SRC3_SEL_BIT = 33;
	localparam logic [PHASE_W-1:0] PHASE_DEG0 = 3'h0;
	localparam logic [PHASE_W-1:0] PHASE_DEG90 = 3'h1;
	localparam logic [PHASE_W-1:0] PHASE_DEG180 = 3'h2;
	localparam logic [PHASE_W-1:0] PHASE_DEG270 = 3'h3;
	localparam logic [EXT_CFG_BITS-1:0] DEFAULT_CFG = 89'h0_0000_0000_0000_0000_4000;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ACTIVE0 = 8'h08;
	localparam logic [ADDR_W-1:0] REG_ACTIVE1 = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_ACTIVE2 = 8'h10;
	localparam logic [ADDR_W-1:0] REG_UPDATES = 8'h14;
	localparam int CTRL_OUT_EN_BIT = 0;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
	localparam int UPDATE_CNT_W = 16;
endpackage

// ---- rtl/cfg_shift_chain.sv ----
// serial shift chain and holding register for the configuration word
`timescale 1ns/1ns
module cfg_shift_chain #(
	parameter int WIDTH = 81,
	parameter logic [WIDTH-1:0] HOLD_RESET = '0
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic shift_pulse,
	input wire logic update_pulse,
	input wire logic serial_in,
	output logic serial_out,
	output logic [WIDTH-1:0] chain_word,
	output logic [WIDTH-1:0] hold_word
);
	logic [WIDTH-1:0] chain_ff;
	logic [WIDTH-1:0] hold_ff;

	// chain moves toward the top bit; the top bit leaves on serial out
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			chain_ff <= '0;
		end else if (shift_pulse) begin
			chain_ff <= {chain_ff[WIDTH-2:0], serial_in};
		end
	end

	// holding copy keeps the live setup steady while new bits stream in
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hold_ff <= HOLD_RESET;
		end else if (update_pulse) begin
			hold_ff <= chain_ff;
		end
	end

	assign serial_out = chain_ff[WIDTH-1];
	assign chain_word = chain_ff;
	assign hold_word = hold_ff;
endmodule // cfg_shift_chain

// ---- rtl/clock_divider.sv ----
// edge counting divider, ratio is divisor plus one
`timescale 1ns/1ns
module clock_divider #(
	parameter int DIV_W = 5
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic src,
	input wire logic [DIV_W-1:0] divisor,
	output logic div_out,
	output logic tick
);
	logic src_prev_ff;
	logic [DIV_W-1:0] cnt_ff;
	logic [DIV_W-1:0] nxt_cnt;
	logic [DIV_W:0] half;
	logic out_ff;
	logic tick_ff;
	logic rise;

	// high for the first ceil(ratio/2) source edges of each period
	always_comb begin
		rise = src & ~src_prev_ff;
		half = DIV_W'(0) + (({1'b0, divisor} + (DIV_W+1)'(2)) >> 1);
		nxt_cnt = (cnt_ff == divisor) ? '0 : cnt_ff + DIV_W'(1);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			src_prev_ff <= 1'b0;
			cnt_ff <= '0;
			out_ff <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			src_prev_ff <= src;
			tick_ff <= rise && (cnt_ff == divisor);
			if (divisor == '0) begin
				out_ff <= src; // ratio one passes the source straight on
				cnt_ff <= '0;
			end else if (rise) begin
				cnt_ff <= nxt_cnt;
				out_ff <= ({1'b0, nxt_cnt} < half);
			end
		end
	end

	assign div_out = out_ff;
	assign tick = tick_ff;
endmodule // clock_divider

// ---- rtl/pll_dynamic_config_port.sv ----
// dynamic configuration port of the clock conditioning circuit
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module pll_dynamic_config_port #(
	parameter bit EXTENDED = 1'b0
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cfg_mode,
	input wire logic cfg_serial_in,
	input wire logic cfg_shift_clock,
	input wire logic cfg_shift_enable,
	input wire logic cfg_update_strobe,
	output logic cfg_serial_out,
	input wire logic ref_clock_in_first,
	input wire logic ref_clock_in_second,
	input wire logic ref_clock_in_third,
	output logic primary_global_out,
	output logic second_global_out,
	output logic third_global_out,
	output logic second_aux_out,
	output logic third_aux_out,
	output logic input_div_out,
	output logic feedback_div_out,
	input wire logic [pll_cfg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata
);
	// extra bits only exist on the extended variant
	localparam int CW = EXTENDED ? pll_cfg_pkg::EXT_CFG_BITS : pll_cfg_pkg::CFG_BITS;
	localparam logic [CW-1:0] DEF_WORD = pll_cfg_pkg::DEFAULT_CFG[CW-1:0];

	logic sclk_prev_ff;
	logic upd_prev_ff;
	logic shift_pulse;
	logic update_pulse;
	logic [CW-1:0] chain_word;
	logic [CW-1:0] hold_word;
	logic [CW-1:0] active_ff;
	logic [CW-1:0] nxt_active;
	logic [1:0] vco_ff;
	logic [3:0] vco_phase;
	logic phase_ff;
	logic [2:0] div_src;
	logic [2:0] div_out;
	logic [2:0][pll_cfg_pkg::OUT_DIV_W-1:0] div_val;
	logic [31:0] control_ff;
	logic [pll_cfg_pkg::UPDATE_CNT_W-1:0] update_cnt_ff;
	logic [95:0] active_padded;
	logic [31:0] nxt_rdata;
	logic fb_tick;
	logic in_tick;
	logic [pll_cfg_pkg::PHASE_W-1:0] phase_code;

	// picks one output divider field out of a configuration word
	function automatic logic [pll_cfg_pkg::OUT_DIV_W-1:0] out_div_field(
		input logic [CW-1:0] word,
		input int idx
	);
		int lsb;
		lsb = (idx == 0) ? pll_cfg_pkg::OUT1_DIV_LSB :
			(idx == 1) ? pll_cfg_pkg::OUT2_DIV_LSB : pll_cfg_pkg::OUT3_DIV_LSB;
		return word[lsb +: pll_cfg_pkg::OUT_DIV_W];
	endfunction

	// shift clock and update are plain synchronous inputs; act on their rising edges
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sclk_prev_ff <= 1'b0;
			upd_prev_ff <= 1'b0;
		end else begin
			sclk_prev_ff <= cfg_shift_clock;
			upd_prev_ff <= cfg_update_strobe;
		end
	end

	// a shift needs the enable during the clock edge; the partner only shifts then updates
	assign shift_pulse = cfg_shift_enable & cfg_shift_clock & ~sclk_prev_ff;
	assign update_pulse = cfg_update_strobe & ~upd_prev_ff;

	cfg_shift_chain #(
		.WIDTH(CW),
		.HOLD_RESET(DEF_WORD)
	) u_chain (
		.sys_clk(sys_clk),
		.reset(reset),
		.shift_pulse(shift_pulse),
		.update_pulse(update_pulse),
		.serial_in(cfg_serial_in),
		.serial_out(cfg_serial_out),
		.chain_word(chain_word),
		.hold_word(hold_word)
	);

	// whole-word source mux; default bits are a constant so nothing can rewrite them
	always_comb begin
		nxt_active = cfg_mode ? hold_word : DEF_WORD;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			active_ff <= DEF_WORD;
		end else begin
			active_ff <= nxt_active;
		end
	end

	// johnson pair gives four oscillator phases a quarter period apart
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vco_ff <= 2'h0;
		end else begin
			vco_ff <= {vco_ff[0], ~vco_ff[1]};
		end
	end

	assign vco_phase = {~vco_ff[1], ~vco_ff[0], vco_ff[1], vco_ff[0]};
	assign phase_code = active_ff[pll_cfg_pkg::PHASE_LSB +: pll_cfg_pkg::PHASE_W];

	// codes above 270 degrees fall back to phase zero rather than float
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phase_ff <= 1'b0;
		end else begin
			unique case (phase_code)
				pll_cfg_pkg::PHASE_DEG0: phase_ff <= vco_phase[0];
				pll_cfg_pkg::PHASE_DEG90: phase_ff <= vco_phase[1];
				pll_cfg_pkg::PHASE_DEG180: phase_ff <= vco_phase[2];
				pll_cfg_pkg::PHASE_DEG270: phase_ff <= vco_phase[3];
				default: phase_ff <= vco_phase[0];
			endcase
		end
	end

	// second and third paths may run from their own inputs only in dynamic mode
	always_comb begin
		div_src[0] = phase_ff;
		div_src[1] = (cfg_mode && active_ff[pll_cfg_pkg::SRC2_SEL_BIT]) ?
			ref_clock_in_second : vco_phase[0];
		div_src[2] = (cfg_mode && active_ff[pll_cfg_pkg::SRC3_SEL_BIT]) ?
			ref_clock_in_third : vco_phase[0];
	end

	// three independent output dividers, one per global path
	generate
		for (genvar g = 0; g < 3; g++) begin : g_out_div
			assign div_val[g] = out_div_field(active_ff, g);
			clock_divider #(
				.DIV_W(pll_cfg_pkg::OUT_DIV_W)
			) u_div (
				.sys_clk(sys_clk),
				.reset(reset),
				.src(div_src[g]),
				.divisor(div_val[g]),
				.div_out(div_out[g]),
				.tick()
			);
		end
	endgenerate

	// input divider ahead of the loop, feedback divider on the oscillator
	clock_divider #(
		.DIV_W(pll_cfg_pkg::LOOP_DIV_W)
	) u_in_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.src(ref_clock_in_first),
		.divisor(active_ff[pll_cfg_pkg::IN_DIV_LSB +: pll_cfg_pkg::LOOP_DIV_W]),
		.div_out(input_div_out),
		.tick(in_tick)
	);

	clock_divider #(
		.DIV_W(pll_cfg_pkg::LOOP_DIV_W)
	) u_fb_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.src(vco_phase[0]),
		.divisor(active_ff[pll_cfg_pkg::FB_DIV_LSB +: pll_cfg_pkg::LOOP_DIV_W]),
		.div_out(feedback_div_out),
		.tick(fb_tick)
	);

	// globals are gated by software; aux outputs always run
	assign primary_global_out = div_out[0] & control_ff[pll_cfg_pkg::CTRL_OUT_EN_BIT];
	assign second_global_out = div_out[1] & control_ff[pll_cfg_pkg::CTRL_OUT_EN_BIT];
	assign third_global_out = div_out[2] & control_ff[pll_cfg_pkg::CTRL_OUT_EN_BIT];
	assign second_aux_out = div_out[1];
	assign third_aux_out = div_out[2];

	// control register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			control_ff <= pll_cfg_pkg::CONTROL_RESET;
		end else if (reg_write && reg_addr == pll_cfg_pkg::REG_CONTROL) begin
			control_ff <= {31'h0, reg_wdata[pll_cfg_pkg::CTRL_OUT_EN_BIT]};
		end
	end

	// counts updates so software can see that a new word was taken; wraps
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			update_cnt_ff <= '0;
		end else if (update_pulse) begin
			update_cnt_ff <= update_cnt_ff + pll_cfg_pkg::UPDATE_CNT_W'(1);
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		active_padded = '0;
		active_padded[CW-1:0] = active_ff;
		nxt_rdata = 32'h0;
		unique case (reg_addr)
			pll_cfg_pkg::REG_CONTROL: nxt_rdata = control_ff;
			pll_cfg_pkg::REG_STATUS: nxt_rdata = {28'h0, feedback_div_out, input_div_out,
				control_ff[pll_cfg_pkg::CTRL_OUT_EN_BIT], cfg_mode};
			pll_cfg_pkg::REG_ACTIVE0: nxt_rdata = active_padded[31:0];
			pll_cfg_pkg::REG_ACTIVE1: nxt_rdata = active_padded[63:32];
			pll_cfg_pkg::REG_ACTIVE2: nxt_rdata = active_padded[95:64];
			pll_cfg_pkg::REG_UPDATES: nxt_rdata = {16'h0, update_cnt_ff};
			default: nxt_rdata = 32'h0;
		endcase
	end

	// read data only stand in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_read ? nxt_rdata : 32'h0;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	property p_source_dynamic;
		cfg_mode |=> (active_ff == $past(hold_word));
	endproperty
	a_source_dynamic: assert property (p_source_dynamic)
		else $error("dynamic mode did not take the holding word");

	property p_source_static;
		!cfg_mode ##1 !cfg_mode |-> (active_ff == DEF_WORD);
	endproperty
	a_source_static: assert property (p_source_static)
		else $error("static mode left the default word");

	property p_shift_in;
		shift_pulse |=> (chain_word[0] == $past(cfg_serial_in)) &&
			(chain_word[CW-1:1] == $past(chain_word[CW-2:0]));
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("shift did not move one bit in");

	property p_shift_hold;
		!shift_pulse |=> $stable(chain_word);
	endproperty
	a_shift_hold: assert property (p_shift_hold)
		else $error("chain moved without a shift");

	property p_serial_out;
		shift_pulse |=> (cfg_serial_out == $past(chain_word[CW-2]));
	endproperty
	a_serial_out: assert property (p_serial_out)
		else $error("serial out did not show the next chain bit");

	property p_update_copy;
		update_pulse |=> (hold_word == $past(chain_word));
	endproperty
	a_update_copy: assert property (p_update_copy)
		else $error("update did not copy the chain");

	property p_hold_stable;
		!update_pulse |=> $stable(hold_word);
	endproperty
	a_hold_stable: assert property (p_hold_stable)
		else $error("holding word changed without update");

	property p_phase_select;
		(phase_code == pll_cfg_pkg::PHASE_DEG180) |=> (phase_ff == $past(vco_phase[2]));
	endproperty
	a_phase_select: assert property (p_phase_select)
		else $error("phase select did not follow 180 degrees");

	property p_vco_quarter;
		vco_phase[1] == $past(vco_phase[0]);
	endproperty
	a_vco_quarter: assert property (p_vco_quarter)
		else $error("phases are not a quarter apart");

	property p_fb_tick_spacing;
		(fb_tick && active_ff[pll_cfg_pkg::FB_DIV_LSB +: pll_cfg_pkg::LOOP_DIV_W] == 7'h0
			&& $stable(active_ff)) |=> !fb_tick [*3];
	endproperty
	a_fb_tick_spacing: assert property (p_fb_tick_spacing)
		else $error("feedback divide by one ticked too soon");

	// the edge detector is cleared by reset, so skip the tick right after it
	property p_in_tick_cause;
		(in_tick && !$past(reset, 2)) |->
			$past(ref_clock_in_first, 1) && !$past(ref_clock_in_first, 2);
	endproperty
	a_in_tick_cause: assert property (p_in_tick_cause)
		else $error("input divider ticked without a source edge");

	property p_rdata_once;
		!$past(reg_read) |-> (reg_rdata == 32'h0);
	endproperty
	a_rdata_once: assert property (p_rdata_once)
		else $error("read data outside the answer cycle");

	property p_rdata_answer;
		(reg_read && reg_addr == pll_cfg_pkg::REG_ACTIVE0) |=>
			(reg_rdata == $past(active_padded[31:0]));
	endproperty
	a_rdata_answer: assert property (p_rdata_answer)
		else $error("active word read did not return the live word");

	property p_control_write;
		(reg_write && reg_addr == pll_cfg_pkg::REG_CONTROL) |=>
			(control_ff == {31'h0, $past(reg_wdata[pll_cfg_pkg::CTRL_OUT_EN_BIT])});
	endproperty
	a_control_write: assert property (p_control_write)
		else $error("control write did not land");

	// count wraps, so compare at the counter width
	property p_update_count;
		update_pulse |=> (update_cnt_ff ==
			pll_cfg_pkg::UPDATE_CNT_W'($past(update_cnt_ff) + pll_cfg_pkg::UPDATE_CNT_W'(1)));
	endproperty
	a_update_count: assert property (p_update_count)
		else $error("update count did not step once");

	property p_primary_bypass;
		(div_val[0] == '0) |=> (div_out[0] == $past(div_src[0]));
	endproperty
	a_primary_bypass: assert property (p_primary_bypass)
		else $error("primary divide by one did not pass the phase");

	c_shift: cover property (shift_pulse ##3 shift_pulse);
	c_update_dyn: cover property (update_pulse ##1 cfg_mode);
	c_mode_switch: cover property (!cfg_mode ##1 cfg_mode);
	c_read_active: cover property (reg_read && reg_addr == pll_cfg_pkg::REG_ACTIVE0);
endmodule // pll_dynamic_config_port

// ---- sim/cfg_port_driver.sv ----
// model of the user logic that feeds the serial configuration port
`timescale 1ns/1ns
module cfg_port_driver (
	input wire logic sys_clk,
	input wire logic cfg_serial_out,
	output logic cfg_serial_in,
	output logic cfg_shift_clock,
	output logic cfg_shift_enable,
	output logic cfg_update_strobe
);
	// idle port: no shift, no update
	initial begin
		cfg_serial_in = 1'b0;
		cfg_shift_clock = 1'b0;
		cfg_shift_enable = 1'b0;
		cfg_update_strobe = 1'b0;
	end

	// shift w in msb first, low phase stretched by gap; got is what came out
	task automatic load(input logic [80:0] w, input int gap, output logic [80:0] got);
		for (int k = 80; k >= 0; k--) begin
			repeat (2 + gap) begin
				@(posedge sys_clk);
				cfg_shift_clock <= 1'b0;
				cfg_shift_enable <= 1'b0;
				// data is not held between bits, so keep it moving
				cfg_serial_in <= ~cfg_serial_in;
			end
			@(posedge sys_clk);
			got[k] = cfg_serial_out;
			cfg_shift_clock <= 1'b1;
			cfg_shift_enable <= 1'b1;
			cfg_serial_in <= w[k];
		end
		@(posedge sys_clk);
		cfg_shift_clock <= 1'b0;
		cfg_shift_enable <= 1'b0;
	endtask

	// one-cycle strobe, then time for holding and active word to settle
	task automatic update();
		@(posedge sys_clk);
		cfg_update_strobe <= 1'b1;
		@(posedge sys_clk);
		cfg_update_strobe <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule // cfg_port_driver

// ---- sim/tb.sv ----
// self-checking bench for the pll dynamic configuration port
`timescale 1ns/1ns
module tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic cfg_mode = 1'b0;
	logic [2:0] rc = 3'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic cfg_serial_in, cfg_shift_clock, cfg_shift_enable, cfg_update_strobe;
	logic cfg_serial_out;
	wire [6:0] outs;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int n;
	int d0;
	logic [80:0] w1, w2, got;
	// periods: oscillator is 4 cycles, reference clocks 2, 6 and 10
	int per[7] = '{20, 16, 12, 16, 12, 14, 24};
	int sh[5] = '{0, 1, 2, 3, 0};
	logic [2:0] ph[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};

	pll_dynamic_config_port #(.EXTENDED(1'b0)) pll_dynamic_config_port_i (
		.sys_clk,
		.reset,
		.cfg_mode,
		.cfg_serial_in,
		.cfg_shift_clock,
		.cfg_shift_enable,
		.cfg_update_strobe,
		.cfg_serial_out,
		.ref_clock_in_first(rc[0]),
		.ref_clock_in_second(rc[1]),
		.ref_clock_in_third(rc[2]),
		.primary_global_out(outs[0]),
		.second_global_out(outs[1]),
		.third_global_out(outs[2]),
		.second_aux_out(outs[3]),
		.third_aux_out(outs[4]),
		.input_div_out(outs[5]),
		.feedback_div_out(outs[6]),
		.reg_addr,
		.reg_wdata,
		.reg_write,
		.reg_read,
		.reg_rdata
	);

	cfg_port_driver cfg_port_driver_i (
		.sys_clk,
		.cfg_serial_out,
		.cfg_serial_in,
		.cfg_shift_clock,
		.cfg_shift_enable,
		.cfg_update_strobe
	);

	always #50 sys_clk = ~sys_clk;

	// distinct reference rates so a wrong clock path shows up in a period
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		rc[0] <= ~rc[0];
		if (cycles % 3 == 0) rc[1] <= ~rc[1];
		if (cycles % 5 == 0) rc[2] <= ~rc[2];
	end

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge sys_clk) begin
		if (cycles == 20000) begin
			errors = errors + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [80:0] g, input logic [80:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		@(posedge sys_clk);
		chk(reg_rdata, e);
	endtask

	// cycles from a rise of output a to the next later rise of output b
	task automatic gap(input int a, input int b, output int r);
		logic pa, pb;
		r = -1;
		pa = outs[a];
		pb = outs[b];
		for (int t = 0; t < 600; t++) begin
			@(posedge sys_clk);
			if (r >= 0) r++;
			if (r > 0 && outs[b] === 1'b1 && pb === 1'b0) break;
			if (r < 0 && outs[a] === 1'b1 && pa === 1'b0) r = 0;
			pa = outs[a];
			pb = outs[b];
		end
	endtask

	function automatic logic [80:0] mk(logic [1:0] s, logic [2:0] p, logic [4:0] c, b, a,
		logic [6:0] f, i);
		return {47'h0, s, p, c, b, a, f, i};
	endfunction

	initial begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		rd(8'h00, 32'h1);
		rd(8'h08, 32'h4000);
		rd(8'h0c, 32'h0);
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h24, 32'h0);
		gap(0, 0, n);
		chk(n, 8);
		// a shifted word must not reach the circuit while the fixed source is chosen
		w1 = mk(2'b00, 3'h1, 5'h2, 5'h3, 5'h4, 7'h5, 7'h6) | {1'b1, 16'h8001, 64'h0};
		cfg_port_driver_i.load(w1, 0, got);
		cfg_port_driver_i.update();
		rd(8'h08, 32'h4000);
		wr(8'h08, 32'hffffffff);
		rd(8'h08, 32'h4000);
		rd(8'h14, 32'h1);
		@(posedge sys_clk);
		cfg_mode <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(8'h08, w1[31:0]);
		rd(8'h0c, w1[63:32]);
		rd(8'h10, {15'h0, w1[80:64]});
		for (int k = 0; k < 7; k++) begin
			gap(k, k, n);
			chk(n, per[k]);
		end
		// slow second load: old word falls out, active word holds until update
		w2 = mk(2'b11, 3'h0, 5'h0, 5'h1, 5'h0, 7'h0, 7'h0);
		cfg_port_driver_i.load(w2, 1, got);
		chk(got, w1);
		rd(8'h08, w1[31:0]);
		cfg_port_driver_i.update();
		rd(8'h0c, 32'h3);
		gap(1, 1, n);
		chk(n, 12);
		gap(2, 2, n);
		chk(n, 10);
		// phase offsets measured against the phase-zero feedback output
		for (int k = 0; k < 5; k++) begin
			w2 = mk(2'b11, ph[k], 5'h0, 5'h0, 5'h0, 7'h0, 7'h0);
			cfg_port_driver_i.load(w2, 0, got);
			cfg_port_driver_i.update();
			gap(6, 0, n);
			if (k == 0) d0 = n;
			chk(n % 4, (d0 + sh[k]) % 4);
		end
		rd(8'h14, 32'h7);
		// gating the globals must leave the second auxiliary output running
		wr(8'h00, 32'h0);
		got = '0;
		repeat (40) begin
			@(posedge sys_clk);
			got[0] = got[0] | outs[0];
		end
		chk(got[0], 1'b0);
		gap(3, 3, n);
		chk(n, 6);
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h1);
		@(posedge sys_clk);
		cfg_mode <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd(8'h08, 32'h4000);
		gap(0, 0, n);
		chk(n, 8);
		report_and_stop();
	end
endmodule // tb
